// [acl_pkg.sv]
// Shared types and constants for the access-control match evaluator
package acl_pkg;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int ACL_ENTRIES   = 16;
  localparam int ACL_CNT_W     = 11;
  localparam int ACL_CNT_MAX   = 2047;

  // ------------------------------------------------------------------
  // Layer and option codes
  // ------------------------------------------------------------------
  localparam logic [1:0] ACL_LAYER_OFF = 2'h0;
  localparam logic [1:0] ACL_LAYER_L2  = 2'h1;
  localparam logic [1:0] ACL_LAYER_L3  = 2'h2;
  localparam logic [1:0] ACL_LAYER_L4  = 2'h3;
  localparam logic [1:0] ACL_OPT_0     = 2'h0;
  localparam logic [1:0] ACL_OPT_1     = 2'h1;
  localparam logic [1:0] ACL_OPT_2     = 2'h2;
  localparam logic [1:0] ACL_OPT_3     = 2'h3;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int ACL_CLK_MHZ     = 125;
  localparam int ACL_US_NS       = 1000;
  localparam int ACL_CLK_NS      = 8;
  localparam int ACL_US_CYCLES   = ACL_US_NS / ACL_CLK_NS;
  localparam int ACL_MS_PER_US   = 1000;
  localparam logic [9:0] ACL_RST_DIV = 10'h0;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  layer;      // match_layer_select
    logic [1:0]  option;     // match_option_select
    logic        src_sel;
    logic        polarity;   // match_polarity
    logic [47:0] mac;
    logic [15:0] ethertype;
    logic [31:0] ipv4_addr;
    logic [31:0] ipv4_ignore; // ipv4_compare_ignore_bits
    logic [15:0] port_max;
    logic [15:0] port_min;
    logic [1:0]  range_mode; // l4_range_test_mode
    logic [7:0]  next_header; // l3_next_header_value
    logic        flag_en;    // tcp_flag_compare_enable
    logic [7:0]  flag_ignore; // tcp_flag_ignore_bits
    logic [7:0]  flag_value;
  } acl_match_t;

  typedef struct packed {
    logic [1:0] prio_mode;   // priority_override_mode
    logic [2:0] prio;
    logic       remark_en;   // remark_enable
    logic [2:0] remark_prio;
    logic [1:0] map_mode;    // forward_map_merge_mode
    logic       time_unit;   // count_time_unit
    logic       algorithm;   // counter_algorithm
  } acl_action_t;

  typedef struct packed {
    logic        is_ipv4;
    logic        is_tcp;
    logic        is_udp;
    logic [47:0] mac_da;
    logic [47:0] mac_sa;
    logic [15:0] ethertype;
    logic [31:0] ip_sa;
    logic [31:0] ip_da;
    logic [7:0]  protocol;
    logic [15:0] l4_sport;
    logic [15:0] l4_dport;
    logic [31:0] tcp_seq;
    logic [7:0]  tcp_flags;
  } acl_hdr_t;

endpackage : acl_pkg

// [acl_tick_gen.sv]
// Microsecond and millisecond tick divider
`timescale 1ns/1ns
module acl_tick_gen
  import acl_pkg::*;
#(
  parameter int US_CYCLES = ACL_US_CYCLES,
  parameter int MS_US     = ACL_MS_PER_US
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  output logic      us_tick,
  output logic      ms_tick
);
  logic [15:0] us_cnt_q;
  logic [9:0]  ms_cnt_q;
  wire         us_wrap = (us_cnt_q == 16'(US_CYCLES - 1));
  wire         ms_wrap = (ms_cnt_q == 10'(MS_US - 1));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      us_cnt_q <= 16'h0;
      ms_cnt_q <= ACL_RST_DIV;
      us_tick  <= 1'b0;
      ms_tick  <= 1'b0;
    end else begin
      us_cnt_q <= us_wrap ? 16'h0 : us_cnt_q + 16'h1;
      us_tick  <= us_wrap;
      ms_tick  <= us_wrap && ms_wrap;
      if (us_wrap) begin
        ms_cnt_q <= ms_wrap ? 10'h0 : ms_cnt_q + 10'h1;
      end
    end
  end
endmodule : acl_tick_gen

// [acl_match_unit.sv]
// Combinational test of one matching entry against one frame header
`timescale 1ns/1ns
module acl_match_unit
  import acl_pkg::*;
(
  input  acl_match_t rule,
  input  acl_hdr_t   hdr,
  output logic       hit
);
  // ------------------------------------------------------------------
  // Field selection
  // ------------------------------------------------------------------
  wire [47:0] mac_f  = rule.src_sel ? hdr.mac_sa : hdr.mac_da;
  wire [31:0] ip_f   = rule.src_sel ? hdr.ip_sa : hdr.ip_da;
  wire [15:0] port_f = rule.src_sel ? hdr.l4_sport : hdr.l4_dport;
  wire        pol    = rule.polarity;

  // ------------------------------------------------------------------
  // Layer 2
  // ------------------------------------------------------------------
  wire mac_ok  = (mac_f == rule.mac) == pol;
  wire type_ok = (hdr.ethertype == rule.ethertype) == pol;
  wire l2_hit  = (rule.option == ACL_OPT_1) ? mac_ok :
                 (rule.option == ACL_OPT_2) ? type_ok :
                 (mac_ok && type_ok);

  // ------------------------------------------------------------------
  // Layer 3
  // ------------------------------------------------------------------
  wire ipv4_compare_ignore_bits_eq = ((ip_f ^ rule.ipv4_addr) & ~rule.ipv4_ignore) == 32'h0;
  wire ip_pair_eq = (hdr.ip_sa == rule.ipv4_addr) &&
                    (hdr.ip_da == rule.ipv4_ignore);
  wire l3_hit     = hdr.is_ipv4 &&
                    ((rule.option == ACL_OPT_1) ? (ipv4_compare_ignore_bits_eq == pol) :
                     (rule.option == ACL_OPT_2) ? (ip_pair_eq == pol) : 1'b0);

  // ------------------------------------------------------------------
  // Layer 4
  // ------------------------------------------------------------------
  // Range test with both bounds inclusive; mode 0 passes
  wire in_rng   = (port_f >= rule.port_min) && (port_f <= rule.port_max);
  wire port_hit = (rule.range_mode == 2'h1) ?
                    ((port_f == rule.port_max) || (port_f == rule.port_min)) :
                  (rule.range_mode == 2'h2) ? in_rng :
                  (rule.range_mode == 2'h3) ? !in_rng : 1'b1;
  wire port_ok  = (rule.range_mode == 2'h0) ? 1'b1 : (port_hit == pol);
  wire seq_ok   = (hdr.tcp_seq == {rule.port_max, rule.port_min}) == pol;
  wire pro_ok   = (hdr.protocol == rule.next_header) == pol;
  wire flag_ok  = !rule.flag_en ||
                  (((hdr.tcp_flags ^ rule.flag_value) & ~rule.flag_ignore) == 8'h0);
  logic l4_hit;
  always_comb begin
    case (rule.option)
      ACL_OPT_0: l4_hit = hdr.is_ipv4 && pro_ok;
      ACL_OPT_1: l4_hit = hdr.is_tcp && port_ok && flag_ok;
      ACL_OPT_2: l4_hit = hdr.is_udp && port_ok;
      default:   l4_hit = hdr.is_tcp && seq_ok && flag_ok;
    endcase
  end

  // ------------------------------------------------------------------
  // Layer select
  // ------------------------------------------------------------------
  always_comb begin
    case (rule.layer)
      ACL_LAYER_L2: hit = l2_hit;
      ACL_LAYER_L3: hit = l3_hit;
      ACL_LAYER_L4: hit = l4_hit;
      default:      hit = 1'b0;
    endcase
  end
endmodule : acl_match_unit

// [acl_match_rule_evaluator.sv]
// Access-control evaluator: matching, processing entries, count mode
`timescale 1ns/1ns
module acl_match_rule_evaluator
  import acl_pkg::*;
#(
  parameter int ENTRIES   = ACL_ENTRIES,
  parameter int NUM_PORTS = 3,
  parameter int IDX_W     = 4,
  parameter int US_CYCLES = ACL_US_CYCLES,
  parameter int MS_US     = ACL_MS_PER_US
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  acl_match_t [ENTRIES-1:0]        match_rules,
  input  acl_action_t [ENTRIES-1:0]       action_rules,
  input  wire logic [ENTRIES-1:0][15:0]   selected_match_set,
  input  wire logic [ENTRIES-1:0][IDX_W-1:0] linked_action_index,
  input  wire logic [ENTRIES-1:0]         proc_enable,
  input  wire logic                       frame_valid,
  input  wire logic [NUM_PORTS-1:0]       frame_port,
  input  acl_hdr_t                        frame_hdr,
  output logic                            result_valid,
  output logic                            action_hit,
  output logic [IDX_W-1:0]                action_index,
  output acl_action_t                     action_out,
  output logic [ENTRIES-1:0]              match_vector,
  output logic [NUM_PORTS-1:0]            count_irq,
  output logic [ENTRIES-1:0]              count_event
);

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  function automatic logic is_count_mode(input acl_match_t r);
    is_count_mode = (r.layer == ACL_LAYER_L2) && (r.option == ACL_OPT_0);
  endfunction : is_count_mode

  function automatic logic [ACL_CNT_W-1:0] count_value(input acl_action_t a);
    count_value = {a.prio_mode, a.prio, a.remark_en, a.remark_prio, a.map_mode};
  endfunction : count_value

  // ------------------------------------------------------------------
  // Time base
  // ------------------------------------------------------------------
  logic us_tick;
  logic ms_tick;

  acl_tick_gen #(
    .US_CYCLES (US_CYCLES),
    .MS_US     (MS_US)
  ) u_tick (
    .sys_clk (sys_clk),
    .rst     (rst),
    .us_tick (us_tick),
    .ms_tick (ms_tick)
  );

  // ------------------------------------------------------------------
  // Matching entries
  // ------------------------------------------------------------------
  logic [ENTRIES-1:0] raw_hit;

  for (genvar i = 0; i < ENTRIES; i++) begin : g_match
    acl_match_unit u_unit (
      .rule (match_rules[i]),
      .hdr  (frame_hdr),
      .hit  (raw_hit[i])
    );
  end

  // ------------------------------------------------------------------
  // Processing entries and priority
  // ------------------------------------------------------------------
  // A count-mode entry still feeds rule sets; only its action slot is taken
  logic [ENTRIES-1:0] proc_true;
  for (genvar p = 0; p < ENTRIES; p++) begin : g_proc
    // An empty rule set never fires, otherwise it would match every frame
    assign proc_true[p] = proc_enable[p] && (selected_match_set[p] != 16'h0) &&
      ((raw_hit & selected_match_set[p][ENTRIES-1:0]) ==
        selected_match_set[p][ENTRIES-1:0]);
  end

  logic             win_any;
  logic [IDX_W-1:0] win_idx;
  always_comb begin
    win_any = 1'b0;
    win_idx = '0;
    for (int p = 0; p < ENTRIES; p++) begin
      if (proc_true[p] && !is_count_mode(match_rules[linked_action_index[p]]) &&
          (!win_any || linked_action_index[p] < win_idx)) begin
        win_any = 1'b1;
        win_idx = linked_action_index[p];
      end
    end
  end

  // ------------------------------------------------------------------
  // Result registers
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result_valid <= 1'b0;
      action_hit   <= 1'b0;
      action_index <= '0;
      action_out   <= '0;
      match_vector <= '0;
    end else begin
      result_valid <= frame_valid;
      action_hit   <= frame_valid && win_any;
      action_index <= win_idx;
      action_out   <= action_rules[win_idx];
      match_vector <= frame_valid ? raw_hit : '0;
    end
  end

  // ------------------------------------------------------------------
  // Count mode counters
  // ------------------------------------------------------------------
  // Each entry owns its counter and the port whose frames last fed it
  logic [ENTRIES-1:0][ACL_CNT_W-1:0] cnt_q;
  logic [ENTRIES-1:0][ACL_CNT_W-1:0] cnt_d;
  logic [ENTRIES-1:0][NUM_PORTS-1:0] own_q;
  logic [ENTRIES-1:0][NUM_PORTS-1:0] own_d;
  logic [ENTRIES-1:0]                fire;
  logic [ENTRIES-1:0]                armed_q;
  logic [ENTRIES-1:0]                armed_d;

  always_comb begin
    for (int e = 0; e < ENTRIES; e++) begin
      logic tick;
      logic seen;
      tick = action_rules[e].time_unit ? ms_tick : us_tick;
      seen = frame_valid && raw_hit[e];
      cnt_d[e]   = cnt_q[e];
      own_d[e]   = seen ? frame_port : own_q[e];
      armed_d[e] = armed_q[e];
      fire[e]    = 1'b0;
      if (!is_count_mode(match_rules[e])) begin
        cnt_d[e]   = '0;
        armed_d[e] = 1'b0;
      end else if (!action_rules[e].algorithm) begin
        // Watchdog: a qualifying frame restarts the interval
        if (seen || !armed_q[e]) begin
          cnt_d[e]   = count_value(action_rules[e]);
          armed_d[e] = 1'b1;
        end else if (tick) begin
          if (cnt_q[e] <= 11'h1) begin
            fire[e]  = 1'b1;
            cnt_d[e] = count_value(action_rules[e]);
          end else begin
            cnt_d[e] = cnt_q[e] - 11'h1;
          end
        end
      end else if (seen) begin
        // Event counter ignores the time unit entirely
        if (cnt_q[e] + 11'h1 >= count_value(action_rules[e])) begin
          fire[e]  = 1'b1;
          cnt_d[e] = '0;
        end else begin
          cnt_d[e] = cnt_q[e] + 11'h1;
        end
      end
    end
  end

  // Only count-mode expiries reach the per-port lines
  logic [NUM_PORTS-1:0] irq_d;
  always_comb begin
    irq_d = '0;
    for (int e = 0; e < ENTRIES; e++) begin
      if (fire[e]) begin
        irq_d = irq_d | own_d[e];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q       <= '0;
      own_q       <= '0;
      armed_q     <= '0;
      count_irq   <= '0;
      count_event <= '0;
    end else begin
      cnt_q       <= cnt_d;
      own_q       <= own_d;
      armed_q     <= armed_d;
      count_irq   <= irq_d;
      count_event <= fire;
    end
  end

endmodule : acl_match_rule_evaluator

// [acl_chk.sv]
// Port assertions for the access-control evaluator
`timescale 1ns/1ns
module acl_chk
  import acl_pkg::*;
#(
  parameter int ENTRIES   = ACL_ENTRIES,
  parameter int NUM_PORTS = 3,
  parameter int IDX_W     = 4
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  acl_match_t [ENTRIES-1:0]  match_rules,
  input  acl_action_t [ENTRIES-1:0] action_rules,
  input  wire logic                 frame_valid,
  input  wire logic                 result_valid,
  input  wire logic                 action_hit,
  input  wire logic [IDX_W-1:0]     action_index,
  input  acl_action_t               action_out,
  input  wire logic [ENTRIES-1:0]   match_vector,
  input  wire logic [NUM_PORTS-1:0] count_irq,
  input  wire logic [ENTRIES-1:0]   count_event
);
  logic [ENTRIES-1:0] dead;
  logic [ENTRIES-1:0] cnt_mode;
  logic [ENTRIES-1:0] by_frame;
  logic [ENTRIES-1:0] by_time;
  always_comb begin
    for (int i = 0; i < ENTRIES; i++) begin
      dead[i]     = match_rules[i].layer == ACL_LAYER_OFF || (match_rules[i].layer == ACL_LAYER_L3
                    && (match_rules[i].option == ACL_OPT_0 || match_rules[i].option == ACL_OPT_3));
      cnt_mode[i] = match_rules[i].layer == ACL_LAYER_L2 && match_rules[i].option == ACL_OPT_0;
      by_frame[i] = cnt_mode[i] && action_rules[i].algorithm;
      by_time[i]  = cnt_mode[i] && !action_rules[i].algorithm;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_take;
    frame_valid;
  endsequence
  sequence s_answer;
    s_take ##1 result_valid;
  endsequence
  property p_answer; s_take |-> s_answer; endproperty
  a_answer: assert property (p_answer) else $error("frame got no result");
  property p_quiet; !frame_valid |=> !result_valid && match_vector == '0; endproperty
  a_quiet: assert property (p_quiet) else $error("result without frame");
  property p_dead; result_valid |-> (match_vector & dead) == '0; endproperty
  a_dead: assert property (p_dead) else $error("disabled entry matched");
  property p_hit_valid; action_hit |-> result_valid; endproperty
  a_hit_valid: assert property (p_hit_valid) else $error("hit outside result");
  property p_out;
    action_hit |-> action_out == action_rules[action_index] && !cnt_mode[action_index];
  endproperty
  a_out: assert property (p_out) else $error("wrong action entry");
  property p_ev_kind; count_event != '0 |-> (count_event & ~cnt_mode) == '0; endproperty
  a_ev_kind: assert property (p_ev_kind) else $error("count event from filter");
  property p_irq_src; count_irq != '0 |-> count_event != '0; endproperty
  a_irq_src: assert property (p_irq_src) else $error("irq without count event");
  property p_ev_frame; (count_event & by_frame) != '0 |-> $past(frame_valid); endproperty
  a_ev_frame: assert property (p_ev_frame) else $error("event count without frame");
  // A qualifying frame reloads the watchdog, so it cannot expire in that cycle
  property p_wd_reload; (count_event & by_time & match_vector) == '0; endproperty
  a_wd_reload: assert property (p_wd_reload) else $error("watchdog fired on frame");
endmodule : acl_chk

bind acl_match_rule_evaluator acl_chk #(.ENTRIES(ENTRIES), .NUM_PORTS(NUM_PORTS), .IDX_W(IDX_W))
  acl_chk_inst (.sys_clk(sys_clk), .rst(rst), .match_rules(match_rules),
  .action_rules(action_rules), .frame_valid(frame_valid), .result_valid(result_valid),
  .action_hit(action_hit), .action_index(action_index), .action_out(action_out),
  .match_vector(match_vector), .count_irq(count_irq), .count_event(count_event));

// [acl_hdr_src.sv]
// Header parser model presenting one frame per request
`timescale 1ns/1ns
module acl_hdr_src
  import acl_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       req,
  input  wire logic [2:0] req_port,
  input  acl_hdr_t        req_hdr,
  output logic            frame_valid,
  output logic [2:0]      frame_port,
  output acl_hdr_t        frame_hdr
);
  // Outside a frame the lines toggle, so a stale header never looks valid
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_valid <= 1'b0;
      frame_hdr   <= '0;
      frame_port  <= 3'h0;
    end else begin
      frame_valid <= req;
      frame_hdr   <= req ? req_hdr : ~frame_hdr;
      frame_port  <= req ? req_port : ~frame_port;
    end
  end
endmodule : acl_hdr_src

// [tb.sv]
// Self-checking bench for the access-control evaluator
`timescale 1ns/1ns
module tb
  import acl_pkg::*;
;
  typedef struct packed {
    logic [15:0] mv;
    logic        hit;
    logic [3:0]  idx;
    logic [15:0] ev;
    logic [2:0]  irq;
  } acl_exp_t;
  localparam int US = 2;
  localparam int MSU = 3;
  logic sys_clk, rst, req, frame_valid, result_valid, action_hit;
  logic [2:0] req_port, frame_port, count_irq;
  logic [15:0] proc_enable, match_vector, count_event;
  logic [15:0][15:0] selected_match_set;
  logic [15:0][3:0] linked_action_index;
  logic [3:0] action_index;
  acl_hdr_t req_hdr, frame_hdr, base;
  acl_match_t [15:0] match_rules;
  acl_action_t [15:0] action_rules;
  acl_action_t action_out;
  acl_exp_t exp_q[$];
  acl_exp_t mon_x;
  int seed = 32'he3bc;
  int err_count, n_checks, ev_cnt, n;
  logic [31:0] c;

  acl_hdr_src acl_hdr_src_inst (.sys_clk(sys_clk), .rst(rst), .req(req), .req_port(req_port),
    .req_hdr(req_hdr), .frame_valid(frame_valid), .frame_port(frame_port), .frame_hdr(frame_hdr));
  acl_match_rule_evaluator #(.US_CYCLES(US), .MS_US(MSU)) acl_match_rule_evaluator_inst (
    .sys_clk(sys_clk), .rst(rst), .match_rules(match_rules), .action_rules(action_rules),
    .selected_match_set(selected_match_set), .linked_action_index(linked_action_index),
    .proc_enable(proc_enable), .frame_valid(frame_valid), .frame_port(frame_port),
    .frame_hdr(frame_hdr), .result_valid(result_valid), .action_hit(action_hit),
    .action_index(action_index), .action_out(action_out), .match_vector(match_vector),
    .count_irq(count_irq), .count_event(count_event));

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      err_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  function automatic acl_hdr_t rnd_hdr();
    logic [287:0] w;
    for (int i = 0; i < 9; i++) w[i*32 +: 32] = $random(seed);
    return w[$bits(acl_hdr_t)-1:0];
  endfunction : rnd_hdr

  function automatic logic ref_hit(input acl_match_t r, input acl_hdr_t h);
    logic [47:0] m;
    logic [31:0] a;
    logic [15:0] p;
    logic        fl;
    logic        rg;
    m  = r.src_sel ? h.mac_sa : h.mac_da;
    a  = r.src_sel ? h.ip_sa : h.ip_da;
    p  = r.src_sel ? h.l4_sport : h.l4_dport;
    fl = !r.flag_en || ((h.tcp_flags ^ r.flag_value) & ~r.flag_ignore) == 8'h0;
    case (r.range_mode)
      2'h0: rg = 1'b1;
      2'h1: rg = (p == r.port_max || p == r.port_min) == r.polarity;
      2'h2: rg = (p >= r.port_min && p <= r.port_max) == r.polarity;
      default: rg = (p < r.port_min || p > r.port_max) == r.polarity;
    endcase
    case ({r.layer, r.option})
      4'h5: return (m == r.mac) == r.polarity;
      4'h6: return (h.ethertype == r.ethertype) == r.polarity;
      4'h4, 4'h7: return (m == r.mac) == r.polarity && (h.ethertype == r.ethertype) == r.polarity;
      4'h9: return h.is_ipv4 && (((a ^ r.ipv4_addr) & ~r.ipv4_ignore) == 32'h0) == r.polarity;
      4'ha: return h.is_ipv4 && (h.ip_sa == r.ipv4_addr && h.ip_da == r.ipv4_ignore) == r.polarity;
      4'hc: return h.is_ipv4 && (h.protocol == r.next_header) == r.polarity;
      4'hd: return h.is_tcp && rg && fl;
      4'he: return h.is_udp && rg;
      4'hf: return h.is_tcp && fl && (h.tcp_seq == {r.port_max, r.port_min}) == r.polarity;
      default: return 1'b0;
    endcase
  endfunction : ref_hit

  function automatic acl_match_t cfg(input int e);
    acl_match_t m;
    m = '0;
    m.layer = 2'(e >> 2);
    m.option = 2'(e);
    {m.src_sel, m.polarity, m.range_mode, m.flag_en} = 5'($random(seed));
    m.mac = m.src_sel ? base.mac_sa : base.mac_da;
    m.ethertype = base.ethertype;
    m.ipv4_addr = (e == 10 || m.src_sel) ? base.ip_sa : base.ip_da;
    m.ipv4_ignore = (e == 10) ? base.ip_da : $random(seed);
    m.port_min = m.src_sel ? base.l4_sport : base.l4_dport;
    m.port_max = m.port_min + 16'h3;
    if (e == 15) {m.port_max, m.port_min} = base.tcp_seq;
    m.next_header = base.protocol;
    m.flag_ignore = 8'($random(seed));
    m.flag_value = base.tcp_flags;
    return m;
  endfunction : cfg

  // Mode 0 is the base frame forced to IPv4 TCP, mode 1 the same without IPv4, mode 2 a random mix
  task automatic send(input int mode);
    acl_hdr_t    h;
    acl_hdr_t    r;
    acl_exp_t    x;
    logic [2:0]  pt;
    acl_action_t ac;
    r = rnd_hdr();
    c = $random(seed);
    h = base;
    ac = action_rules[4];
    if (mode == 2) begin
      if (c[0]) h.mac_da = r.mac_da;
      if (c[1]) h.mac_sa = r.mac_sa;
      if (c[2]) h.ethertype = r.ethertype;
      if (c[3]) h.ip_sa = r.ip_sa;
      if (c[4]) h.ip_da = r.ip_da;
      if (c[5]) h.protocol = r.protocol;
      if (c[6]) h.tcp_seq = r.tcp_seq;
      if (c[7]) h.tcp_flags = r.tcp_flags;
      h.l4_sport = base.l4_sport + 16'(c[10:8]) - 16'h2;
      h.l4_dport = base.l4_dport + 16'(c[13:11]) - 16'h2;
      h.is_ipv4 = c[14] | c[15];
      h.is_tcp = h.is_ipv4 & c[16];
      h.is_udp = h.is_ipv4 & ~c[16];
    end
    {h.is_ipv4, h.is_tcp, h.is_udp} = (mode == 0) ? 3'h6 : (mode == 1) ? 3'h0 : h[258:256];
    pt = 3'h1 << (c[18:17] % 2'h3);
    for (int e = 0; e < 16; e++) x.mv[e] = ref_hit(match_rules[e], h);
    x.hit = 1'b0;
    x.idx = 4'h0;
    for (int p = 0; p < 16; p++)
      if (proc_enable[p] && selected_match_set[p] != 16'h0 && (selected_match_set[p] & ~x.mv) == 16'h0
          && linked_action_index[p] != 4'h4 && (!x.hit || linked_action_index[p] < x.idx)) begin
        x.hit = 1'b1;
        x.idx = linked_action_index[p];
      end
    x.ev = 16'h0;
    x.irq = 3'h0;
    if (x.mv[4] && ac.algorithm) begin
      ev_cnt++;
      if (ev_cnt >= int'({ac.prio_mode, ac.prio, ac.remark_en, ac.remark_prio, ac.map_mode})) begin
        x.ev[4] = 1'b1;
        x.irq = pt;
        ev_cnt = 0;
      end
    end
    @(posedge sys_clk);
    if (c[20:19] == 2'h0) begin
      req <= 1'b0;
      @(posedge sys_clk);
    end
    req <= 1'b1;
    req_hdr <= h;
    req_port <= pt;
    exp_q.push_back(x);
  endtask : send

  task automatic wait_ev(output int k);
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (count_event[4] !== 1'b1 && k < 500);
    if (k >= 500) begin
      err_count++;
      print_verdict();
    end
  endtask : wait_ev

  // Watchdog with no traffic: the gap between expiries is the full count interval
  task automatic wd_run(input logic tu);
    rst <= 1'b1;
    action_rules[4] <= {2'h0, 3'h0, 1'h0, 3'h1, 2'h2, tu, 1'h0};
    // Equality polarity so the base frame keeps feeding the watchdog
    match_rules[4].polarity <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    wait_ev(n);
    wait_ev(n);
    chk(32'(n), 32'(6 * US * (tu ? MSU : 1)));
    chk(32'(count_irq), 32'h0);
    // Frames closer together than the interval must hold the watchdog off
    if (!tu) begin
      repeat (20) send(0);
      @(posedge sys_clk);
      req <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk(32'(exp_q.size()), 32'h0);
    end
  endtask : wd_run

  always @(posedge sys_clk) begin
    if (!rst && result_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0);
      else begin
        mon_x = exp_q.pop_front();
        chk(32'(match_vector), 32'(mon_x.mv));
        chk(32'(action_hit), 32'(mon_x.hit));
        if (mon_x.hit) chk(32'(action_index), 32'(mon_x.idx));
        if (mon_x.hit) chk(32'(action_out), 32'(action_rules[mon_x.idx]));
        chk(32'(count_event), 32'(mon_x.ev));
        chk(32'(count_irq), 32'(mon_x.irq));
      end
    end
  end

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial begin
    rst = 1'b1;
    req = 1'b0;
    req_port = 3'h0;
    req_hdr = '0;
    err_count = 0;
    n_checks = 0;
    ev_cnt = 0;
    base = rnd_hdr();
    base.l4_sport = (base.l4_sport & 16'h7fff) | 16'h0100;
    base.l4_dport = (base.l4_dport & 16'h7fff) | 16'h0100;
    for (int p = 0; p < 16; p++) begin
      match_rules[p] = cfg(p);
      action_rules[p] = acl_action_t'($random(seed));
      c = $random(seed);
      selected_match_set[p] = (16'h10 << (c[3:0] % 4'hc)) | (c[4] ? 16'h10 << (c[8:5] % 4'hc) : 16'h0);
      linked_action_index[p] = c[12:9];
      proc_enable[p] = c[15:13] != 3'h0;
    end
    selected_match_set[15] = 16'h0;
    proc_enable[15] = 1'b1;
    // Count value 5 spans the remark and map fields of the action entry
    action_rules[4] = {2'h0, 3'h0, 1'h0, 3'h1, 2'h1, 1'h0, 1'h1};
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    send(0);
    send(1);
    send(0);
    repeat (400) send(2);
    @(posedge sys_clk);
    req <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(32'(exp_q.size()), 32'h0);
    wd_run(1'b0);
    wd_run(1'b1);
    print_verdict();
  end
endmodule : tb
